/* logic/aux_relay_defs.vh */
// constants for the auxiliary relay status selector
`ifndef AUX_RELAY_DEFS_VH
`define AUX_RELAY_DEFS_VH

// register byte offsets
`define REG_RELAY0_CFG 8'h00
`define REG_RELAY1_CFG 8'h04
`define REG_FAULT_EN 8'h08
`define REG_WARN_EN 8'h0C
`define REG_LIVE 8'h10
`define REG_IRQ_STAT 8'h14
`define REG_IRQ_MASK 8'h18

// relay configuration register fields
`define CFG_OPT_HI 3
`define CFG_OPT_LO 0
`define CFG_E0_HI 14
`define CFG_E0_LO 8
`define CFG_E1_HI 22
`define CFG_E1_LO 16
`define CFG_E2_HI 30
`define CFG_E2_LO 24

// custom code entry fields: valid, kind (1 = warning), code index
`define ENT_VALID 6
`define ENT_WARN 5
`define ENT_IDX_HI 4
`define ENT_IDX_LO 0

// relay option encodings
`define OPT_OFF 4'h0
`define OPT_FAULT 4'h1
`define OPT_FAULT_NOT 4'h2
`define OPT_BYPASS 4'h3
`define OPT_BYPASS_NOT 4'h4
`define OPT_ENERG 4'h5
`define OPT_ENERG_NOT 4'h6
`define OPT_WARN 4'h7
`define OPT_WARN_NOT 4'h8
`define OPT_CUSTOM 4'h9
`define OPT_CUSTOM_NOT 4'hA

// live status register fields
`define LIVE_R0 0
`define LIVE_R1 1
`define LIVE_REP0_HI 14
`define LIVE_REP0_LO 8
`define LIVE_REP1_HI 22
`define LIVE_REP1_LO 16

// interrupt status bits
`define IRQ_R0_CHG 0
`define IRQ_R1_CHG 1
`define IRQ_FAULT 2
`define IRQ_WARN 3
`define IRQ_W 4

// reset values
`define CFG_RST 32'h0000_0000
`define EN_RST 32'hFFFF_FFFF
`define ZERO32 32'h0000_0000
`define ZERO7 7'h00

`endif

/* logic/aux_relay_status_select.v */
// two-relay auxiliary status selector with register port and interrupt
// Contract
// - option 1 any fault, option 2 inverted
// - option 3 bypass closed, option 4 inverted
// - option 5 motor energized, option 6 inverted
// - option 7 any warning, option 8 inverted
// - options 9/10 custom list, three entries max
// - custom entries mix fault and warning codes
// - custom relay is OR over entries
// - simultaneous codes report faults before warnings
// - disabled protection code never triggers custom relay
`timescale 1ns/1ps
`include "aux_relay_defs.vh"

module aux_relay_status_select (
   // clock, reset and the register port
   input wire clk_i,
   input wire resetn_i,
   input wire [7:0] addr_i,
   input wire [31:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output wire [31:0] rdata_o,
   // live protection codes and motor state from the starter core
   input wire [31:0] fault_codes_i,
   input wire [31:0] warn_codes_i,
   input wire bypass_closed_i,
   input wire start_ramp_i,
   input wire run_i,
   input wire soft_stop_i,
   input wire pump_stop_i,
   // contacts and interrupt, all straight from flops
   output wire relay0_o,
   output wire relay1_o,
   output wire irq_o
);

   // software-visible registers
   reg [31:0] cfg_q [0:1];
   reg [31:0] fault_en_q;
   reg [31:0] warn_en_q;
   reg [`IRQ_W-1:0] irq_stat_q;
   reg [`IRQ_W-1:0] irq_mask_q;
   reg [31:0] rdata_q;
   // output and edge-detect flops
   reg [1:0] relay_q;
   reg [6:0] rep_q [0:1];
   reg fault_any_q;
   reg warn_any_q;
   reg irq_q;

   // per-relay results and summary sources
   wire [1:0] relay_d;
   wire [6:0] rep_d [0:1];
   wire fault_any;
   wire warn_any;
   wire energized;

   // interrupt bookkeeping
   wire [`IRQ_W-1:0] irq_set;
   wire [`IRQ_W-1:0] irq_clr;
   wire [`IRQ_W-1:0] irq_next;
   wire [`IRQ_W-1:0] mask_next;

   // register write enables and read words
   wire wr_cfg0;
   wire wr_cfg1;
   wire wr_fault_en;
   wire wr_warn_en;
   wire wr_mask;
   wire wr_stat;
   wire [31:0] stat_word;
   wire [31:0] mask_word;
   reg [31:0] live_word;
   reg [31:0] rdata_d;

   // one custom entry is live only if valid, present and its protection enabled;
   // the kind bit picks which code bank the index points into
   function entry_hit;
      input [6:0] ent;
      input [31:0] fc;
      input [31:0] wc;
      input [31:0] fen;
      input [31:0] wen;
      reg [4:0] idx;
      reg present;
      reg enabled;
      begin
         idx = ent[`ENT_IDX_HI:`ENT_IDX_LO];
         if (ent[`ENT_WARN]) begin
            present = wc[idx];
            enabled = wen[idx];
         end else begin
            present = fc[idx];
            enabled = fen[idx];
         end
         // a disabled protection drops out of the OR entirely
         entry_hit = ent[`ENT_VALID] & present & enabled;
      end
   endfunction

   // relay drive from option and the status sources
   function relay_sel;
      input [3:0] opt;
      input flt;
      input byp;
      input eng;
      input wrn;
      input cus;
      begin
         case (opt)
            `OPT_FAULT: relay_sel = flt;
            `OPT_FAULT_NOT: relay_sel = ~flt;
            `OPT_BYPASS: relay_sel = byp;
            `OPT_BYPASS_NOT: relay_sel = ~byp;
            `OPT_ENERG: relay_sel = eng;
            `OPT_ENERG_NOT: relay_sel = ~eng;
            `OPT_WARN: relay_sel = wrn;
            `OPT_WARN_NOT: relay_sel = ~wrn;
            `OPT_CUSTOM: relay_sel = cus;
            `OPT_CUSTOM_NOT: relay_sel = ~cus;
            default: relay_sel = 1'b0; // (unused codes also stay off)
         endcase
      end
   endfunction

   // summary sources; enables gate only the custom list, not the plain options
   assign fault_any = |fault_codes_i;
   assign warn_any = |warn_codes_i;
   assign energized = start_ramp_i | run_i | soft_stop_i | pump_stop_i;

   // two identical relay channels
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : relay_gen
         wire [6:0] e0;
         wire [6:0] e1;
         wire [6:0] e2;
         wire h0;
         wire h1;
         wire h2;
         wire custom;
         reg [6:0] rep;
         reg [6:0] flt_rep;
         reg [6:0] wrn_rep;
         assign e0 = cfg_q[g][`CFG_E0_HI:`CFG_E0_LO];
         assign e1 = cfg_q[g][`CFG_E1_HI:`CFG_E1_LO];
         assign e2 = cfg_q[g][`CFG_E2_HI:`CFG_E2_LO];
         assign h0 = entry_hit(e0, fault_codes_i, warn_codes_i, fault_en_q, warn_en_q);
         assign h1 = entry_hit(e1, fault_codes_i, warn_codes_i, fault_en_q, warn_en_q);
         assign h2 = entry_hit(e2, fault_codes_i, warn_codes_i, fault_en_q, warn_en_q);
         // any single selected code is enough
         assign custom = h0 | h1 | h2;
         assign relay_d[g] = relay_sel(cfg_q[g][`CFG_OPT_HI:`CFG_OPT_LO], fault_any,
            bypass_closed_i, energized, warn_any, custom);
         // reported code: first fault hit in entry order, else first warning hit
         always @* begin
            flt_rep = `ZERO7;
            wrn_rep = `ZERO7;
            if (h2 & ~e2[`ENT_WARN])
               flt_rep = e2;
            if (h1 & ~e1[`ENT_WARN])
               flt_rep = e1;
            if (h0 & ~e0[`ENT_WARN])
               flt_rep = e0;
            if (h2 & e2[`ENT_WARN])
               wrn_rep = e2;
            if (h1 & e1[`ENT_WARN])
               wrn_rep = e1;
            if (h0 & e0[`ENT_WARN])
               wrn_rep = e0;
            // faults win over warnings when several codes stand together
            if (flt_rep[`ENT_VALID])
               rep = flt_rep;
            else
               rep = wrn_rep;
         end
         assign rep_d[g] = rep;
      end
   endgenerate

   // register write decode, shared by every writable register and the clear
   function wr_to;
      input we;
      input [7:0] a;
      input [7:0] target;
      begin
         wr_to = we & (a == target);
      end
   endfunction

   // write enables, one per writable register; writes to the live word fall away
   assign wr_cfg0 = wr_to(wr_i, addr_i, `REG_RELAY0_CFG);
   assign wr_cfg1 = wr_to(wr_i, addr_i, `REG_RELAY1_CFG);
   assign wr_fault_en = wr_to(wr_i, addr_i, `REG_FAULT_EN);
   assign wr_warn_en = wr_to(wr_i, addr_i, `REG_WARN_EN);
   assign wr_mask = wr_to(wr_i, addr_i, `REG_IRQ_MASK);
   assign wr_stat = wr_to(wr_i, addr_i, `REG_IRQ_STAT);

   // relay configuration words; option 0 out of reset keeps both contacts off
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cfg_q[0] <= `CFG_RST;
         cfg_q[1] <= `CFG_RST;
      end else begin
         if (wr_cfg0)
            cfg_q[0] <= wdata_i;
         if (wr_cfg1)
            cfg_q[1] <= wdata_i;
      end
   end

   // protection enables reset to on, so every selected code counts until disabled
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         fault_en_q <= `EN_RST;
         warn_en_q <= `EN_RST;
      end else begin
         if (wr_fault_en)
            fault_en_q <= wdata_i;
         if (wr_warn_en)
            warn_en_q <= wdata_i;
      end
   end

   // mask next value; only the event bits exist, upper write data are dropped
   assign mask_next = wr_mask ? wdata_i[`IRQ_W-1:0] : irq_mask_q;

   // interrupt mask
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i)
         irq_mask_q <= {`IRQ_W{1'b0}};
      else
         irq_mask_q <= mask_next;
   end

   // relay contacts, one cycle behind the sources
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i)
         relay_q <= {2{1'b0}};
      else
         relay_q <= relay_d;
   end

   // reported codes, kept in step with the relay they belong to
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rep_q[0] <= `ZERO7;
         rep_q[1] <= `ZERO7;
      end else begin
         rep_q[0] <= rep_d[0];
         rep_q[1] <= rep_d[1];
      end
   end

   // previous summary levels, kept only to spot a rising fault or warning
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         fault_any_q <= 1'b0;
         warn_any_q <= 1'b0;
      end else begin
         fault_any_q <= fault_any;
         warn_any_q <= warn_any;
      end
   end

   // events: either relay toggling, a rising summary fault or a rising warning
   assign irq_set[`IRQ_R0_CHG] = relay_d[0] ^ relay_q[0];
   assign irq_set[`IRQ_R1_CHG] = relay_d[1] ^ relay_q[1];
   assign irq_set[`IRQ_FAULT] = fault_any & ~fault_any_q;
   assign irq_set[`IRQ_WARN] = warn_any & ~warn_any_q;

   // write-one-to-clear; set beats a same-cycle clear so no event is lost
   assign irq_clr = wr_stat ? wdata_i[`IRQ_W-1:0] : {`IRQ_W{1'b0}};
   assign irq_next = (irq_stat_q & ~irq_clr) | irq_set;

   // sticky status
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i)
         irq_stat_q <= {`IRQ_W{1'b0}};
      else
         irq_stat_q <= irq_next;
   end

   // level interrupt from the values the status and mask flops are about to
   // hold, so irq_o moves on the same edge as the status bit behind it
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i)
         irq_q <= 1'b0;
      else
         irq_q <= |(irq_next & mask_next);
   end

   // live status word assembled field by field
   always @* begin
      live_word = `ZERO32;
      live_word[`LIVE_R0] = relay_q[0];
      live_word[`LIVE_R1] = relay_q[1];
      live_word[`LIVE_REP0_HI:`LIVE_REP0_LO] = rep_q[0];
      live_word[`LIVE_REP1_HI:`LIVE_REP1_LO] = rep_q[1];
   end

   // status and mask widened to a bus word
   assign stat_word = {{(32-`IRQ_W){1'b0}}, irq_stat_q};
   assign mask_word = {{(32-`IRQ_W){1'b0}}, irq_mask_q};

   // read mux; unmapped addresses and idle cycles read as zero
   always @* begin
      rdata_d = `ZERO32;
      if (rd_i) begin
         case (addr_i)
            `REG_RELAY0_CFG: rdata_d = cfg_q[0];
            `REG_RELAY1_CFG: rdata_d = cfg_q[1];
            `REG_FAULT_EN: rdata_d = fault_en_q;
            `REG_WARN_EN: rdata_d = warn_en_q;
            `REG_LIVE: rdata_d = live_word;
            `REG_IRQ_STAT: rdata_d = stat_word;
            `REG_IRQ_MASK: rdata_d = mask_word;
            default: rdata_d = `ZERO32;
         endcase
      end
   end

   // read data stand only in the cycle after the strobe
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i)
         rdata_q <= `ZERO32;
      else
         rdata_q <= rdata_d;
   end

   // outputs straight from flops; contact debounce is left to the far end
   assign relay0_o = relay_q[0];
   assign relay1_o = relay_q[1];
   assign irq_o = irq_q;
   assign rdata_o = rdata_q;

endmodule // aux_relay_status_select

/* sim/plc_input_model.sv */
// plc input model that qualifies a relay contact change
`timescale 1ns/1ps
module plc_input_model #(parameter int QUAL = 8) (
   input wire logic clk_i,
   input wire logic contact_i,
   output logic seen_o
);
   int n = 0;
   // contact starts out seen as open
   initial seen_o = 1'b0;
   // a change must hold QUAL+1 cycles so shock bounces never reach the plc logic
   always @(posedge clk_i) begin
      n <= (contact_i == seen_o) ? 0 : n + 1;
      if (n == QUAL) seen_o <= contact_i;
   end
endmodule // plc_input_model

/* sim/aux_relay_status_select_asserts.sv */
// checker for relay 0 source selection
`timescale 1ns/1ps
`include "aux_relay_defs.vh"
module aux_relay_status_select_asserts (
   input wire clk_i,
   input wire resetn_i,
   input wire [7:0] addr_i,
   input wire [31:0] wdata_i,
   input wire wr_i,
   input wire [31:0] fault_codes_i,
   input wire [31:0] warn_codes_i,
   input wire bypass_closed_i,
   input wire start_ramp_i,
   input wire run_i,
   input wire soft_stop_i,
   input wire pump_stop_i,
   input wire relay0_o
);
   reg [3:0] c_q;
   reg [3:0] p_q;
   reg f_q, w_q, b_q, e_q, z_q;
   // shadow of the option, delayed to line up with the registered relay
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         c_q <= 4'h0;
         p_q <= 4'h0;
      end else begin
         if (wr_i && addr_i == `REG_RELAY0_CFG) c_q <= wdata_i[3:0];
         p_q <= c_q;
      end
   end
   // sources one cycle old, as the relay sees them
   always @(posedge clk_i) begin
      f_q <= |fault_codes_i;
      w_q <= |warn_codes_i;
      b_q <= bypass_closed_i;
      e_q <= start_ramp_i | run_i | soft_stop_i | pump_stop_i;
      z_q <= ~|{fault_codes_i, warn_codes_i};
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   a_opt_off: assert property (p_q == 4'h0 || p_q > 4'hA |-> !relay0_o)
      else $error("relay on when off");
   a_fault_follow: assert property (p_q == 4'h1 || p_q == 4'h2 |-> relay0_o == (f_q ^ p_q[1]))
      else $error("fault relay wrong");
   a_bypass_follow: assert property (p_q == 4'h3 || p_q == 4'h4 |-> relay0_o == (b_q ^ p_q[2]))
      else $error("bypass relay wrong");
   a_energ_follow: assert property (p_q == 4'h5 || p_q == 4'h6 |-> relay0_o == (e_q ^ p_q[1]))
      else $error("energized relay wrong");
   a_warn_follow: assert property (p_q == 4'h7 || p_q == 4'h8 |-> relay0_o == (w_q ^ p_q[3]))
      else $error("warning relay wrong");
   a_custom_idle: assert property (p_q == 4'h9 && z_q |-> !relay0_o)
      else $error("custom relay without code");
   a_custom_inv: assert property (p_q == 4'hA && z_q |-> relay0_o)
      else $error("inverted custom relay wrong");
   a_off_write: assert property (wr_i && addr_i == 8'h00 && wdata_i[3:0] == 4'h0 |-> ##2 !relay0_o)
      else $error("relay on after off write");
   cover property (p_q == 4'h9 && relay0_o);
   cover property (p_q == 4'h5 && relay0_o);
   cover property (p_q == 4'hA && relay0_o);
endmodule // aux_relay_status_select_asserts
bind aux_relay_status_select aux_relay_status_select_asserts aux_relay_status_select_asserts_i (
   .clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
   .fault_codes_i(fault_codes_i), .warn_codes_i(warn_codes_i), .bypass_closed_i(bypass_closed_i),
   .start_ramp_i(start_ramp_i), .run_i(run_i), .soft_stop_i(soft_stop_i),
   .pump_stop_i(pump_stop_i), .relay0_o(relay0_o));

/* sim/aux_relay_status_select_tb.sv */
// testbench for the relay status selector
`timescale 1ns/1ps
`include "aux_relay_defs.vh"
module aux_relay_status_select_tb;
   logic clk_i = 0, resetn_i = 0, wr_i = 0, rd_i = 0, relay0_o, relay1_o, irq_o, seen;
   logic [7:0] addr_i = 8'h00;
   logic [4:0] s = 5'h00;
   logic [31:0] wdata_i = `ZERO32, f = `ZERO32, w = `ZERO32, rdata_o;
   int n_fail = 0, num_checks = 0;
   always #12.5 clk_i = ~clk_i;
   aux_relay_status_select aux_relay_status_select_i (.clk_i(clk_i), .resetn_i(resetn_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .fault_codes_i(f), .warn_codes_i(w), .bypass_closed_i(s[4]), .start_ramp_i(s[3]),
      .run_i(s[2]), .soft_stop_i(s[1]), .pump_stop_i(s[0]), .relay0_o(relay0_o),
      .relay1_o(relay1_o), .irq_o(irq_o));
   plc_input_model plc_input_model_i (.clk_i(clk_i), .contact_i(relay1_o), .seen_o(seen));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      wr_i <= 1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 0;
   endtask
   // read data stand only in the cycle after the strobe
   task rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk_i);
      rd_i <= 1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 0;
      #1 chk(rdata_o, exp);
   endtask
   task drv(input logic [31:0] fc, input logic [31:0] wc, input logic [4:0] st);
      @(posedge clk_i);
      f <= fc;
      w <= wc;
      s <= st;
      repeat (3) @(posedge clk_i);
      #1;
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // run takes a few hundred cycles
   initial begin
      #100000;
      n_fail++;
      give_verdict;
   end
   initial begin
      repeat (3) @(posedge clk_i);
      resetn_i <= 1;
      rd(`REG_FAULT_EN, `EN_RST);
      rd(`REG_IRQ_MASK, `ZERO32);
      rd(8'h1C, `ZERO32);
      // every option with fault, warning, bypass and energized sources active, then all idle
      for (int k = 0; k < 16; k++) begin
         wr(`REG_RELAY0_CFG, k);
         drv(1, 1, 5'h1F);
         chk(relay0_o, (k > 0 && k < 9) ? k[0] : (k == 10));
         drv(0, 0, 5'h00);
         chk(relay0_o, (k > 0 && k < 9) ? !k[0] : (k == 10));
      end
      // each energized phase alone; start_ramp_i stands for the start_command_input
      wr(`REG_RELAY0_CFG, 5);
      for (int k = 0; k < 4; k++) begin
         drv(0, 0, 5'h01 << k);
         chk(relay0_o, 1);
      end
      // entry 0 fault code 3, entry 1 warning code 7
      wr(`REG_RELAY0_CFG, 32'h0067_4309);
      drv(0, 32'h0000_0080, 5'h00);
      rd(`REG_LIVE, 32'h0000_6701);
      drv(8, 32'h0000_0080, 5'h00);
      rd(`REG_LIVE, 32'h0000_4301);
      drv(32'h0000_0020, 0, 5'h00);
      chk(relay0_o, 0);
      wr(`REG_FAULT_EN, 32'hFFFF_FFF7);
      drv(8, 0, 5'h00);
      chk(relay0_o, 0);
      wr(`REG_RELAY0_CFG, 32'h0067_430A);
      drv(8, 0, 5'h00);
      chk(relay0_o, 1);
      // all codes idle first, so the next fault is a real rising edge
      drv(0, 0, 5'h00);
      chk(relay0_o, 1);
      // fault rise on relay 1 with only the fault interrupt unmasked
      wr(`REG_IRQ_MASK, 32'h0000_0004);
      wr(`REG_RELAY1_CFG, 1);
      wr(`REG_IRQ_STAT, 32'h0000_000F);
      drv(1, 0, 5'h00);
      chk({relay1_o, irq_o}, 2'b11);
      rd(`REG_IRQ_STAT, 32'h0000_0006);
      wr(`REG_IRQ_STAT, 32'h0000_0004);
      drv(1, 0, 5'h00);
      chk(irq_o, 0);
      repeat (12) @(posedge clk_i);
      chk(seen, 1);
      give_verdict;
   end
endmodule // aux_relay_status_select_tb
